/* File: quad_phase_fetch_execute_timing.sv */
`timescale 1ns/1ps
`include "qpfe_defines.svh"
// How it works
// - divide input clock into four phases
// - program counter increments in phase one
// - capture fetched word in phase four
// - load instruction register phase one, execute after
// - operand read phase two, result write four
// - fetch overlaps execute, one per cycle
// - counter-changing instruction costs two cycles
// - config field selects one of four modes
// - quarter-rate clock out in RC mode
// - crystal modes accept external clock input
// - master clear low holds reset
module quad_phase_fetch_execute_timing #(
  parameter int PC_W = `QPFE_PC_W_DEFAULT,
  parameter int INSTR_W = `QPFE_INSTR_W_DEFAULT,
  parameter int DATA_ADDR_W = `QPFE_DATA_ADDR_W_DEFAULT,
  parameter int DATA_W = `QPFE_DATA_W_DEFAULT,
  parameter logic [3:0] SUPPORTED_MODES = `QPFE_SUPPORTED_DEFAULT,
  parameter logic [PC_W-1:0] RESET_VECTOR = '1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_master_clear_pin_n,
  input wire qpfe_pkg::osc_sel_t i_osc_select_bits,
  output logic o_osc_output_pin,
  output qpfe_pkg::osc_mode_t o_osc_mode,
  output logic o_mode_unsupported,
  output logic o_phase_one,
  output logic o_phase_two,
  output logic o_phase_three,
  output logic o_phase_four,
  output logic [PC_W-1:0] o_program_counter,
  input wire logic [INSTR_W-1:0] i_prog_data,
  output logic [INSTR_W-1:0] o_instr,
  output logic o_exec_valid,
  input wire logic [DATA_W-1:0] i_result,
  input wire logic i_result_we,
  input wire logic i_jump,
  input wire logic [PC_W-1:0] i_jump_target,
  output logic [DATA_ADDR_W-1:0] o_data_addr,
  output logic o_data_rd,
  input wire logic [DATA_W-1:0] i_data_rdata,
  output logic [DATA_W-1:0] o_operand,
  output logic o_data_wr,
  output logic [DATA_W-1:0] o_data_wdata
);
  import qpfe_pkg::*;

  generate
    if (PC_W < 2 || PC_W > 16 || DATA_W < 1 ||
        DATA_ADDR_W + `QPFE_ADDR_FIELD_LSB > INSTR_W) begin : g_bad_params
      $error("unsupported parameter set");
    end
  endgenerate

  phase_if ph ();

  logic pin_rst;
  logic core_rst;
  logic unsupported;
  logic [PC_W-1:0] pc_reg;
  logic [INSTR_W-1:0] fetch_reg;
  logic fetch_valid_reg;
  logic [INSTR_W-1:0] ir_reg;
  logic exec_valid_reg;
  logic [DATA_ADDR_W-1:0] data_addr_reg;
  logic rd_reg;
  logic [DATA_W-1:0] operand_reg;
  logic wr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic jump_now;

  // master clear is active low; an unsupported mode also holds the core
  assign pin_rst = i_rst || !i_master_clear_pin_n;
  assign core_rst = pin_rst || unsupported;
  assign jump_now = exec_valid_reg && ph.phase_four && i_jump;

  phase_gen u_phase_gen (
    .i_clk(i_clk),
    .i_rst(core_rst),
    .ph(ph.gen)
  );

  osc_mode #(
    .SUPPORTED_MODES(SUPPORTED_MODES)
  ) u_osc_mode (
    .i_clk(i_clk),
    .i_rst(pin_rst),
    .i_osc_select_bits(i_osc_select_bits),
    .ph(ph.sink),
    .o_mode(o_osc_mode),
    .o_unsupported(unsupported),
    .o_osc_output_pin(o_osc_output_pin)
  );

  // program counter: +1 in phase one, jump loads target-1 so the next phase one hits target
  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      pc_reg <= RESET_VECTOR;
    end else if (ph.phase_one) begin
      pc_reg <= pc_reg + 1'b1;
    end else if (jump_now) begin
      pc_reg <= i_jump_target - 1'b1;
    end
  end

  // fetch stage, word captured at the end of phase four
  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      fetch_reg <= '0;
      fetch_valid_reg <= 1'b0;
    end else if (ph.phase_four) begin
      fetch_reg <= i_prog_data;
      fetch_valid_reg <= !jump_now;
    end
  end

  // execute stage, loaded in phase one while the next fetch starts
  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      ir_reg <= '0;
      exec_valid_reg <= 1'b0;
      data_addr_reg <= '0;
    end else if (ph.phase_one) begin
      ir_reg <= fetch_reg;
      exec_valid_reg <= fetch_valid_reg;
      data_addr_reg <= fetch_reg[`QPFE_ADDR_FIELD_LSB +: DATA_ADDR_W];
    end
  end

  // operand read strobe stands through phase two
  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      rd_reg <= 1'b0;
      operand_reg <= '0;
    end else begin
      rd_reg <= ph.phase_one && fetch_valid_reg;
      if (rd_reg) begin
        operand_reg <= i_data_rdata;
      end
    end
  end

  // destination write strobe stands through phase four
  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      wr_reg <= 1'b0;
      wdata_reg <= '0;
    end else begin
      wr_reg <= ph.phase_three && exec_valid_reg && i_result_we;
      if (ph.phase_three) begin
        wdata_reg <= i_result;
      end
    end
  end

  assign o_phase_one = ph.phase_one;
  assign o_phase_two = ph.phase_two;
  assign o_phase_three = ph.phase_three;
  assign o_phase_four = ph.phase_four;
  assign o_mode_unsupported = unsupported;
  assign o_program_counter = pc_reg;
  assign o_instr = ir_reg;
  assign o_exec_valid = exec_valid_reg;
  assign o_data_addr = data_addr_reg;
  assign o_data_rd = rd_reg;
  assign o_operand = operand_reg;
  assign o_data_wr = wr_reg;
  assign o_data_wdata = wdata_reg;

  property p_pc_inc;
    @(posedge i_clk) disable iff (core_rst)
      ph.phase_one |=> (pc_reg == $past(pc_reg) + 1'b1);
  endproperty
  a_pc_inc: assert property (p_pc_inc) else $error("counter not stepped in phase one");

  property p_pc_steady;
    @(posedge i_clk) disable iff (core_rst)
      (ph.phase_two || ph.phase_three) |=> $stable(pc_reg);
  endproperty
  a_pc_steady: assert property (p_pc_steady) else $error("counter moved outside phase one");

  property p_fetch;
    @(posedge i_clk) disable iff (core_rst)
      ph.phase_four && !jump_now |=> fetch_valid_reg && (fetch_reg == $past(i_prog_data));
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch word not captured");

  property p_ir_load;
    @(posedge i_clk) disable iff (core_rst)
      ph.phase_one |=> (ir_reg == $past(fetch_reg)) && (exec_valid_reg == $past(fetch_valid_reg));
  endproperty
  a_ir_load: assert property (p_ir_load) else $error("instruction register not loaded");

  property p_rd_phase;
    @(posedge i_clk) disable iff (core_rst)
      o_data_rd == (ph.phase_two && exec_valid_reg);
  endproperty
  a_rd_phase: assert property (p_rd_phase) else $error("read strobe outside phase two");

  property p_wr_phase;
    @(posedge i_clk) disable iff (core_rst)
      o_data_wr |-> ph.phase_four && exec_valid_reg && $past(i_result_we);
  endproperty
  a_wr_phase: assert property (p_wr_phase) else $error("write strobe outside phase four");

  property p_seq_flow;
    @(posedge i_clk) disable iff (core_rst)
      exec_valid_reg && ph.phase_four && !i_jump |=> ##1 exec_valid_reg [*4];
  endproperty
  a_seq_flow: assert property (p_seq_flow) else $error("bubble in sequential flow");

  property p_jump_bubble;
    @(posedge i_clk) disable iff (core_rst)
      jump_now |=> (pc_reg == $past(i_jump_target) - 1'b1) ##1 !exec_valid_reg [*4];
  endproperty
  a_jump_bubble: assert property (p_jump_bubble) else $error("jump did not cost a cycle");

  property p_master_clear_pin;
    @(posedge i_clk)
      !i_master_clear_pin_n |=> !exec_valid_reg && !fetch_valid_reg && ph.phase_one &&
                                (pc_reg == RESET_VECTOR);
  endproperty
  a_master_clear_pin: assert property (p_master_clear_pin) else $error("master clear did not reset");

  property p_operand_capture;
    @(posedge i_clk) disable iff (core_rst)
      o_data_rd |=> (o_operand == $past(i_data_rdata));
  endproperty
  a_operand_capture: assert property (p_operand_capture) else $error("operand not taken");

  property p_operand_hold;
    @(posedge i_clk) disable iff (core_rst)
      !o_data_rd |=> $stable(o_operand);
  endproperty
  a_operand_hold: assert property (p_operand_hold) else $error("operand moved without read");

  property p_wdata_capture;
    @(posedge i_clk) disable iff (core_rst)
      ph.phase_three |=> (o_data_wdata == $past(i_result));
  endproperty
  a_wdata_capture: assert property (p_wdata_capture) else $error("result not taken");

  property p_wr_needs_we;
    @(posedge i_clk) disable iff (core_rst)
      ph.phase_three && exec_valid_reg && i_result_we |=> o_data_wr;
  endproperty
  a_wr_needs_we: assert property (p_wr_needs_we) else $error("write strobe missing");

  property p_wr_once;
    @(posedge i_clk) disable iff (core_rst)
      o_data_wr |=> !o_data_wr;
  endproperty
  a_wr_once: assert property (p_wr_once) else $error("write strobe too long");

  property p_strobes_apart;
    @(posedge i_clk) disable iff (core_rst)
      !(o_data_rd && o_data_wr);
  endproperty
  a_strobes_apart: assert property (p_strobes_apart) else $error("read and write together");

  property p_rd_after_load;
    @(posedge i_clk) disable iff (core_rst)
      ph.phase_one && fetch_valid_reg |=> o_data_rd;
  endproperty
  a_rd_after_load: assert property (p_rd_after_load) else $error("read strobe missing");

  property p_addr_field;
    @(posedge i_clk) disable iff (core_rst)
      ph.phase_one |=> (data_addr_reg == $past(fetch_reg[`QPFE_ADDR_FIELD_LSB +: DATA_ADDR_W]));
  endproperty
  a_addr_field: assert property (p_addr_field) else $error("data address not from word");

  property p_ir_hold;
    @(posedge i_clk) disable iff (core_rst)
      !ph.phase_one |=> $stable(ir_reg);
  endproperty
  a_ir_hold: assert property (p_ir_hold) else $error("instruction moved mid cycle");

  property p_fetch_hold;
    @(posedge i_clk) disable iff (core_rst)
      !ph.phase_four |=> $stable(fetch_reg);
  endproperty
  a_fetch_hold: assert property (p_fetch_hold) else $error("fetch word moved mid cycle");

  property p_exec_hold_valid;
    @(posedge i_clk) disable iff (core_rst)
      !ph.phase_one |=> $stable(exec_valid_reg);
  endproperty
  a_exec_hold_valid: assert property (p_exec_hold_valid) else $error("valid moved mid cycle");

  property p_pc_jump_only;
    @(posedge i_clk) disable iff (core_rst)
      ph.phase_four && !jump_now |=> $stable(pc_reg);
  endproperty
  a_pc_jump_only: assert property (p_pc_jump_only) else $error("counter moved in phase four");

  property p_jump_discard;
    @(posedge i_clk) disable iff (core_rst)
      jump_now |=> !fetch_valid_reg;
  endproperty
  a_jump_discard: assert property (p_jump_discard) else $error("stale fetch kept");

  property p_jump_target;
    @(posedge i_clk) disable iff (core_rst)
      jump_now |=> ##1 (pc_reg == $past(i_jump_target, 2));
  endproperty
  a_jump_target: assert property (p_jump_target) else $error("target not reached");

  property p_unsupported_hold;
    @(posedge i_clk) disable iff (pin_rst)
      unsupported |=> ph.phase_one && !exec_valid_reg;
  endproperty
  a_unsupported_hold: assert property (p_unsupported_hold) else $error("core ran unsupported");
endmodule

/* File: qpfe_defines.svh */
`ifndef QPFE_DEFINES_SVH
`define QPFE_DEFINES_SVH

`define QPFE_OSC_SEL_W 2
`define QPFE_OSC_SEL_LP 2'h0
`define QPFE_OSC_SEL_XT 2'h1
`define QPFE_OSC_SEL_HS 2'h2
`define QPFE_OSC_SEL_RC 2'h3
`define QPFE_SUPPORTED_DEFAULT 4'hf
`define QPFE_PC_W_DEFAULT 11
`define QPFE_INSTR_W_DEFAULT 12
`define QPFE_DATA_ADDR_W_DEFAULT 7
`define QPFE_DATA_W_DEFAULT 8
`define QPFE_ADDR_FIELD_LSB 0

`endif

/* File: qpfe_pkg.sv */
package qpfe_pkg;
  typedef logic [1:0] osc_sel_t;
  typedef enum logic [1:0] {
    low_power_crystal_mode,
    crystal_resonator_mode,
    high_speed_crystal_mode,
    resistor_capacitor_mode
  } osc_mode_t;
  typedef enum {
    st_phase_one,
    st_phase_two,
    st_phase_three,
    st_phase_four
  } phase_t;
endpackage

/* File: phase_if.sv */
`timescale 1ns/1ps
interface phase_if;
  logic phase_one;
  logic phase_two;
  logic phase_three;
  logic phase_four;
  modport gen (output phase_one, output phase_two, output phase_three, output phase_four);
  modport sink (input phase_one, input phase_two, input phase_three, input phase_four);
endinterface

/* File: phase_gen.sv */
`timescale 1ns/1ps
module phase_gen (
  input wire logic i_clk,
  input wire logic i_rst,
  phase_if.gen ph
);
  import qpfe_pkg::*;

  phase_t state_reg;
  phase_t state_next;

  // divide by four into one-hot phases
  always_comb begin
    case (state_reg)
      st_phase_one: state_next = st_phase_two;
      st_phase_two: state_next = st_phase_three;
      st_phase_three: state_next = st_phase_four;
      st_phase_four: state_next = st_phase_one;
      default: state_next = st_phase_one;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= st_phase_one;
    end else begin
      state_reg <= state_next;
    end
  end

  assign ph.phase_one = (state_reg == st_phase_one);
  assign ph.phase_two = (state_reg == st_phase_two);
  assign ph.phase_three = (state_reg == st_phase_three);
  assign ph.phase_four = (state_reg == st_phase_four);

  property p_phase_onehot;
    @(posedge i_clk) disable iff (i_rst)
      $onehot({ph.phase_one, ph.phase_two, ph.phase_three, ph.phase_four});
  endproperty
  a_phase_onehot: assert property (p_phase_onehot) else $error("phases not one-hot");

  property p_phase_cycle;
    @(posedge i_clk) disable iff (i_rst)
      ph.phase_one |=> ph.phase_two ##1 ph.phase_three ##1 ph.phase_four ##1 ph.phase_one;
  endproperty
  a_phase_cycle: assert property (p_phase_cycle) else $error("phase order broken");

  property p_phase_restart;
    @(posedge i_clk) $past(i_rst) |-> ph.phase_one;
  endproperty
  a_phase_restart: assert property (p_phase_restart) else $error("no restart at phase one");
endmodule

/* File: osc_mode.sv */
`timescale 1ns/1ps
`include "qpfe_defines.svh"
module osc_mode #(
  parameter logic [3:0] SUPPORTED_MODES = `QPFE_SUPPORTED_DEFAULT
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire qpfe_pkg::osc_sel_t i_osc_select_bits,
  phase_if.sink ph,
  output qpfe_pkg::osc_mode_t o_mode,
  output logic o_unsupported,
  output logic o_osc_output_pin
);
  import qpfe_pkg::*;

  osc_mode_t mode_reg;
  osc_mode_t mode_next;
  logic unsupported_reg;
  logic osc_out_reg;

  // decode of the configuration field
  always_comb begin
    if (i_osc_select_bits == `QPFE_OSC_SEL_LP) begin
      mode_next = low_power_crystal_mode;
    end else if (i_osc_select_bits == `QPFE_OSC_SEL_XT) begin
      mode_next = crystal_resonator_mode;
    end else if (i_osc_select_bits == `QPFE_OSC_SEL_HS) begin
      mode_next = high_speed_crystal_mode;
    end else begin
      mode_next = resistor_capacitor_mode;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_reg <= crystal_resonator_mode;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // variant without a mode holds the core; set at reset so the core never runs early
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      unsupported_reg <= 1'b1;
    end else begin
      unsupported_reg <= ~SUPPORTED_MODES[i_osc_select_bits];
    end
  end

  // quarter-rate clock out, high in phases three and four
  // crystal modes leave the pin low; i_clk is the crystal or external clock alike
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      osc_out_reg <= 1'b0;
    end else begin
      osc_out_reg <= (mode_reg == resistor_capacitor_mode) &&
                     (ph.phase_two || ph.phase_three);
    end
  end

  assign o_mode = mode_reg;
  assign o_unsupported = unsupported_reg;
  assign o_osc_output_pin = osc_out_reg;

  property p_rc_high;
    @(posedge i_clk) disable iff (i_rst)
      (mode_reg == resistor_capacitor_mode) && $past(mode_reg == resistor_capacitor_mode) &&
      (ph.phase_three || ph.phase_four) |-> o_osc_output_pin;
  endproperty
  a_rc_high: assert property (p_rc_high) else $error("clock out low in phase three or four");

  property p_rc_low;
    @(posedge i_clk) disable iff (i_rst)
      (ph.phase_one || ph.phase_two) |-> !o_osc_output_pin;
  endproperty
  a_rc_low: assert property (p_rc_low) else $error("clock out high in phase one or two");

  property p_xtal_quiet;
    @(posedge i_clk) disable iff (i_rst)
      (mode_reg != resistor_capacitor_mode) |=> !o_osc_output_pin;
  endproperty
  a_xtal_quiet: assert property (p_xtal_quiet) else $error("clock out in crystal mode");

  property p_unsupported;
    @(posedge i_clk) disable iff (i_rst)
      1'b1 |=> (o_unsupported == !SUPPORTED_MODES[$past(i_osc_select_bits)]);
  endproperty
  a_unsupported: assert property (p_unsupported) else $error("support flag wrong");
endmodule

/* File: qpfe_mem_model.sv */
`timescale 1ns/1ps
module qpfe_mem_model (
  input wire logic [10:0] i_prog_addr,
  input wire logic [6:0] i_data_addr,
  input wire logic i_data_rd,
  output logic [11:0] o_prog_word,
  output logic [7:0] o_data_word
);
  logic [7:0] val;
  // program word follows the fetch address
  assign o_prog_word = {1'b0, i_prog_addr} ^ 12'h5a5;
  // released read bus shows the inverse, not the last value
  assign val = {1'b0, i_data_addr} + 8'h11;
  assign o_data_word = i_data_rd ? val : ~val;
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import qpfe_pkg::*;
  logic i_clk, i_rst, i_master_clear_pin_n, i_result_we, i_jump;
  osc_sel_t i_osc_select_bits;
  osc_mode_t o_osc_mode;
  logic [7:0] i_result, i_data_rdata, o_operand, o_data_wdata;
  logic [11:0] i_prog_data, o_instr;
  logic [10:0] o_program_counter, i_jump_target;
  logic [6:0] o_data_addr;
  logic o_osc_output_pin, o_mode_unsupported, o_exec_valid, o_data_rd, o_data_wr;
  logic o_phase_one, o_phase_two, o_phase_three, o_phase_four;
  logic [3:0] ph;
  int err_count, cmp_count, cycles;
  assign ph = {o_phase_four, o_phase_three, o_phase_two, o_phase_one};
  quad_phase_fetch_execute_timing DUT (
    .i_clk(i_clk), .i_rst(i_rst), .i_master_clear_pin_n(i_master_clear_pin_n),
    .i_osc_select_bits(i_osc_select_bits), .o_osc_output_pin(o_osc_output_pin),
    .o_osc_mode(o_osc_mode), .o_mode_unsupported(o_mode_unsupported),
    .o_phase_one(o_phase_one), .o_phase_two(o_phase_two), .o_phase_three(o_phase_three),
    .o_phase_four(o_phase_four), .o_program_counter(o_program_counter),
    .i_prog_data(i_prog_data), .o_instr(o_instr), .o_exec_valid(o_exec_valid),
    .i_result(i_result), .i_result_we(i_result_we), .i_jump(i_jump),
    .i_jump_target(i_jump_target), .o_data_addr(o_data_addr), .o_data_rd(o_data_rd),
    .i_data_rdata(i_data_rdata), .o_operand(o_operand), .o_data_wr(o_data_wr),
    .o_data_wdata(o_data_wdata)
  );
  qpfe_mem_model mem (
    .i_prog_addr(o_program_counter), .i_data_addr(o_data_addr), .i_data_rd(o_data_rd),
    .o_prog_word(i_prog_data), .o_data_word(i_data_rdata)
  );
  // external clock source on the oscillator input
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  task results;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  function automatic logic [11:0] word_at(input logic [10:0] a);
    return {1'b0, a} ^ 12'h5a5;
  endfunction
  task wait_ph(input int n);
    int k;
    for (k = 0; k < 40; k++) begin
      @(negedge i_clk);
      if (ph[n] === 1'b1) break;
    end
    check(ph[n], 1, "phase wait");
  endtask
  task t_phases;
    int k;
    logic [10:0] a;
    wait_ph(0);
    for (k = 0; k < 8; k++) begin
      check(ph, 32'h1 << (k % 4), "phase order");
      if (k == 1) a = o_program_counter;
      if (k == 5) check(o_program_counter, 11'(a + 11'h1), "count step");
      @(negedge i_clk);
    end
  endtask
  task t_pipe;
    int k;
    logic [11:0] w;
    for (k = 0; k < 6; k++) begin
      wait_ph(1);
      w = word_at(11'(o_program_counter - 11'h1));
      check(o_exec_valid, 1, "exec valid");
      check(o_instr, w, "fetched word");
      check(o_data_addr, w[6:0], "data address");
      check(o_data_rd, 1, "read strobe");
      i_result = 8'h30 + 8'(k);
      i_result_we = k[0];
      @(negedge i_clk);
      check(o_operand, 8'({1'b0, w[6:0]} + 8'h11), "operand");
      check(o_data_rd, 0, "read strobe width");
      @(negedge i_clk);
      check(o_data_wr, k[0], "write strobe");
      check(o_data_wdata, 8'h30 + 8'(k), "write data");
      @(negedge i_clk);
      check(o_phase_one, 1, "next cycle start");
      check(o_instr, w, "instr held to phase one");
    end
  endtask
  task t_jump;
    wait_ph(3);
    i_jump = 1'b1;
    i_jump_target = 11'h123;
    @(negedge i_clk);
    i_jump = 1'b0;
    wait_ph(1);
    check(o_exec_valid, 0, "bubble after jump");
    wait_ph(1);
    check(o_exec_valid, 1, "target valid");
    check(o_instr, word_at(11'h123), "target word");
    check(o_program_counter, 11'h124, "count after jump");
  endtask
  task t_master_clear_pin;
    wait_ph(2);
    i_master_clear_pin_n = 1'b0;
    @(negedge i_clk);
    @(negedge i_clk);
    check(o_program_counter, 11'h7ff, "held vector");
    check(ph, 1, "held phase");
    check(o_exec_valid, 0, "held exec");
    i_master_clear_pin_n = 1'b1;
    wait_ph(1);
    check(o_program_counter, 0, "first fetch address");
    check(o_exec_valid, 0, "empty pipeline");
    wait_ph(1);
    check(o_instr, word_at(11'h0), "first word");
  endtask
  task t_osc;
    int m, k;
    for (m = 0; m < 4; m++) begin
      i_osc_select_bits = 2'(m);
      wait_ph(0);
      wait_ph(0);
      check(o_osc_mode, m, "mode decode");
      check(o_mode_unsupported, 0, "mode accepted");
      for (k = 0; k < 4; k++) begin
        check(o_osc_output_pin, (m == 3) && (k >= 2), "clock out");
        @(negedge i_clk);
      end
    end
    i_osc_select_bits = 2'h0;
  endtask
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 4000) begin
      err_count++;
      results();
    end
  end
  initial begin
    i_rst = 1'b1;
    i_master_clear_pin_n = 1'b1;
    i_osc_select_bits = 2'h1;
    i_result = 8'h0;
    i_result_we = 1'b0;
    i_jump = 1'b0;
    i_jump_target = 11'h0;
    repeat (3) @(negedge i_clk);
    i_rst = 1'b0;
    t_phases();
    t_pipe();
    t_jump();
    t_pipe();
    t_master_clear_pin();
    t_osc();
    t_pipe();
    results();
  end
endmodule
